// >>> src/ttc_pkg.sv
// ****************************************************************
// Thermal throttle control constants and carriers
// ****************************************************************
package ttc_pkg;

  // Clock rate and minimum engage time
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint MIN_ENGAGE_PS = 64'd1000000000; // 1 ms
  localparam int MIN_ENGAGE_CYCLES = int'(MIN_ENGAGE_PS / CLK_PERIOD_PS);

  // Register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 64;

  // Register indices on the plain register port
  localparam logic [3:0] REG_MISC_EN = 4'h0;
  localparam logic [3:0] REG_XFER_CTL = 4'h1;
  localparam logic [3:0] REG_PERF_TGT = 4'h2;
  localparam logic [3:0] REG_THERM_STAT = 4'h3;
  localparam logic [3:0] REG_FEAT_EDX = 4'h4;
  localparam logic [3:0] REG_FEAT_ECX = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;
  localparam logic [3:0] REG_OP_POINT = 4'h8;

  // Field positions
  localparam int MISC_DUTY_EN_BIT = 3;
  localparam int MISC_FV_EN_BIT = 13;
  localparam int XFER_SELECT_BIT = 16;
  localparam int XFER_TARGET_W = 16;
  localparam int STAT_HOT_BIT = 0;
  localparam int FEAT_EDX_DUTY_BIT = 29;
  localparam int FEAT_ECX_FV_BIT = 8;

  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_ENGAGE_BIT = 0;
  localparam int IRQ_RELEASE_BIT = 1;
  localparam int IRQ_CATAS_BIT = 2;

  // Duty-cycle modulation shape
  localparam int DUTY_DIV = 16;
  localparam int DUTY_STEPS = 8;
  localparam int DUTY_ON_STEPS = 4;

  // Reset values
  localparam logic [XFER_TARGET_W-1:0] OP_POINT_RESET = 16'h0000;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ttc_req_s;

endpackage : ttc_pkg

// >>> src/ttc_top.sv
// Function
// - Catastrophic trip halts execution permanently until the next reset.
// - Catastrophic trip also engages throttling, as the lower sensor must have tripped.
// - Duty-cycle method gates the core clock internally, never via external stop-clock pin.
// - Feature query leaf 1 reports duty-cycle support in EDX bit 29.
// - Misc enable bit 3 turns on duty-cycle method; reset clears it.
// - Frequency/voltage method uses the same sensor and lowers frequency and voltage.
// - Feature query leaf 1 reports frequency/voltage support in ECX bit 8.
// - Early scheme: frequency/voltage method needs select bit 16 and enable bit 3.
// - Early scheme: enable bit 3 with select clear chooses the duty-cycle method.
// - Later scheme: misc enable bit 13 turns on frequency/voltage method.
// - Frequency/voltage throttle moves to the target in transition control bits 15:0.
// - Under duty-cycle throttling a performance target write takes effect at once.
// - Under freq/voltage throttling a performance target write waits for release.
// - Throttling holds at least about 1 ms, then until cooled past hysteresis.
// - Thermal status bit 0 reads set exactly while throttling reduces power.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module ttc_top #(
  parameter int MIN_ENGAGE_CYCLES = ttc_pkg::MIN_ENGAGE_CYCLES,
  parameter bit EARLY_SCHEME = 1'b0,
  parameter bit DUTY_SUPPORTED = 1'b1,
  parameter bit FV_SUPPORTED = 1'b1
) (
  input wire logic clk_i, // Core clock, 250 MHz
  input wire logic reset_i, // Synchronous reset, active high
  input wire ttc_pkg::ttc_req_s req_i, // Register request
  output logic [ttc_pkg::DATA_W-1:0] rdata_o, // Read data, cycle after read
  input wire logic catas_trip_i, // Catastrophic sensor, asynchronous
  input wire logic sensor_trip_i, // Throttle sensor tripped, asynchronous
  input wire logic temp_cool_i, // Below trip less hysteresis, asynchronous
  output logic halt_o, // Execution halted
  output logic clock_run_o, // Core clock allowed this cycle
  output logic fv_active_o, // Frequency/voltage throttle engaged
  output logic [ttc_pkg::XFER_TARGET_W-1:0] op_point_o, // Applied frequency/voltage code
  output logic irq_o // Level interrupt
);

  localparam int HOLD_W = $clog2(MIN_ENGAGE_CYCLES + 1);
  localparam int DIV_W = $clog2(ttc_pkg::DUTY_DIV);
  localparam int PH_W = $clog2(ttc_pkg::DUTY_STEPS);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic catas_s;
  logic trip_s;
  logic cool_s;

  // Two flops per asynchronous sensor pin
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {catas_trip_i, sensor_trip_i, temp_cool_i};
      pin_s2 <= pin_s1;
    end
  end

  assign catas_s = pin_s2[2];
  assign trip_s = pin_s2[1];
  assign cool_s = pin_s2[0];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [ttc_pkg::DATA_W-1:0] misc_feature_enable_reg;
  logic [ttc_pkg::DATA_W-1:0] thermal_transition_control;
  logic [ttc_pkg::XFER_TARGET_W-1:0] performance_target_reg;
  logic [ttc_pkg::IRQ_W-1:0] irq_stat;
  logic [ttc_pkg::IRQ_W-1:0] irq_mask;
  logic [ttc_pkg::IRQ_W-1:0] irq_event;
  logic wr_misc;
  logic wr_xfer;
  logic wr_perf;

  // Write decode shared by the register processes
  function automatic logic hit(input ttc_pkg::ttc_req_s r, input logic [3:0] idx);
    hit = r.wr && (r.addr == idx);
  endfunction : hit

  assign wr_misc = hit(req_i, ttc_pkg::REG_MISC_EN);
  assign wr_xfer = hit(req_i, ttc_pkg::REG_XFER_CTL);
  assign wr_perf = hit(req_i, ttc_pkg::REG_PERF_TGT);

  // Enable bits; only the two documented enables are kept
  // reset clears enables
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      misc_feature_enable_reg <= '0;
    end else if (wr_misc) begin
      misc_feature_enable_reg <= '0;
      misc_feature_enable_reg[ttc_pkg::MISC_DUTY_EN_BIT] <=
        req_i.wdata[ttc_pkg::MISC_DUTY_EN_BIT];
      misc_feature_enable_reg[ttc_pkg::MISC_FV_EN_BIT] <=
        req_i.wdata[ttc_pkg::MISC_FV_EN_BIT];
    end
  end

  // Transition target and method select; upper bits reserved
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      thermal_transition_control <= '0;
    end else if (wr_xfer) begin
      thermal_transition_control <= '0;
      thermal_transition_control[ttc_pkg::XFER_SELECT_BIT] <=
        req_i.wdata[ttc_pkg::XFER_SELECT_BIT];
      thermal_transition_control[ttc_pkg::XFER_TARGET_W-1:0] <=
        req_i.wdata[ttc_pkg::XFER_TARGET_W-1:0];
    end
  end

  // Software performance target, applied below when allowed
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      performance_target_reg <= ttc_pkg::OP_POINT_RESET;
    end else if (wr_perf) begin
      performance_target_reg <= req_i.wdata[ttc_pkg::XFER_TARGET_W-1:0];
    end
  end

  // ****************************************************************
  // Method selection and trip hold
  // ****************************************************************
  logic duty_en;
  logic fv_en;
  logic tripped;
  logic engaged;
  logic duty_active;
  logic fv_active;
  logic [HOLD_W-1:0] hold_cnt;

  // Enable schemes: the early one gates by the select flag
  always_comb begin
    if (EARLY_SCHEME) begin
      fv_en = FV_SUPPORTED && misc_feature_enable_reg[ttc_pkg::MISC_DUTY_EN_BIT]
        && thermal_transition_control[ttc_pkg::XFER_SELECT_BIT];
      duty_en = DUTY_SUPPORTED && misc_feature_enable_reg[ttc_pkg::MISC_DUTY_EN_BIT]
        && !thermal_transition_control[ttc_pkg::XFER_SELECT_BIT];
    end else begin
      fv_en = FV_SUPPORTED && misc_feature_enable_reg[ttc_pkg::MISC_FV_EN_BIT];
      // Freq/voltage wins when both are set, only one action runs at a time
      duty_en = DUTY_SUPPORTED && misc_feature_enable_reg[ttc_pkg::MISC_DUTY_EN_BIT]
        && !fv_en;
    end
  end

  assign engaged = tripped && (duty_en || fv_en);
  assign duty_active = engaged && duty_en;
  assign fv_active = engaged && fv_en;

  // Trip latch with minimum hold; a retrip restarts the hold
  // hold then hysteresis release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tripped <= 1'b0;
      hold_cnt <= '0;
    end else if (trip_s || catas_s) begin
      tripped <= 1'b1;
      hold_cnt <= HOLD_W'(MIN_ENGAGE_CYCLES - 1);
    end else if (tripped && hold_cnt != '0) begin
      hold_cnt <= hold_cnt - HOLD_W'(1);
    end else if (tripped && cool_s) begin
      tripped <= 1'b0;
    end
  end

  // ****************************************************************
  // Catastrophic halt
  // ****************************************************************
  // halt until reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      halt_o <= 1'b0;
    end else if (catas_s) begin
      halt_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Duty-cycle clock gating
  // ****************************************************************
  logic [DIV_W-1:0] div_cnt;
  logic [PH_W-1:0] phase;
  logic step_en;

  // Divider makes the modulation step pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= (div_cnt == DIV_W'(ttc_pkg::DUTY_DIV - 1)) ? '0 : div_cnt + DIV_W'(1);
    end
  end

  assign step_en = (div_cnt == DIV_W'(ttc_pkg::DUTY_DIV - 1));

  // Phase restarts when idle so each throttle episode starts clocked
  always_ff @(posedge clk_i) begin
    if (reset_i || !duty_active) begin
      phase <= '0;
    end else if (step_en) begin
      phase <= phase + PH_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clock_run_o <= 1'b1;
    end else begin
      clock_run_o <= !halt_o && !catas_s
        && !(duty_active && phase >= PH_W'(ttc_pkg::DUTY_ON_STEPS));
    end
  end

  // ****************************************************************
  // Operating point
  // ****************************************************************
  // freq/voltage target applied
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      op_point_o <= ttc_pkg::OP_POINT_RESET;
      fv_active_o <= 1'b0;
    end else begin
      fv_active_o <= fv_active;
      if (fv_active) begin
        op_point_o <= thermal_transition_control[ttc_pkg::XFER_TARGET_W-1:0];
      end else if (wr_perf) begin
        op_point_o <= req_i.wdata[ttc_pkg::XFER_TARGET_W-1:0];
      end else begin
        op_point_o <= performance_target_reg;
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic engaged_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      engaged_q <= 1'b0;
    end else begin
      engaged_q <= engaged;
    end
  end

  assign irq_event[ttc_pkg::IRQ_ENGAGE_BIT] = engaged && !engaged_q;
  assign irq_event[ttc_pkg::IRQ_RELEASE_BIT] = !engaged && engaged_q;
  assign irq_event[ttc_pkg::IRQ_CATAS_BIT] = catas_s && !halt_o;

  // Sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_stat <= '0;
    end else if (hit(req_i, ttc_pkg::REG_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~req_i.wdata[ttc_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_mask <= '0;
    end else if (hit(req_i, ttc_pkg::REG_IRQ_MASK)) begin
      irq_mask <= req_i.wdata[ttc_pkg::IRQ_W-1:0];
    end
  end

  // Registered, so it trails status by one cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped indices read zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (req_i.rd) begin
      rdata_o <= '0;
      case (req_i.addr)
        ttc_pkg::REG_MISC_EN: rdata_o <= misc_feature_enable_reg;
        ttc_pkg::REG_XFER_CTL: rdata_o <= thermal_transition_control;
        ttc_pkg::REG_PERF_TGT: rdata_o[ttc_pkg::XFER_TARGET_W-1:0] <= performance_target_reg;
        ttc_pkg::REG_THERM_STAT: rdata_o[ttc_pkg::STAT_HOT_BIT] <= engaged;
        ttc_pkg::REG_FEAT_EDX: rdata_o[ttc_pkg::FEAT_EDX_DUTY_BIT] <= DUTY_SUPPORTED;
        ttc_pkg::REG_FEAT_ECX: rdata_o[ttc_pkg::FEAT_ECX_FV_BIT] <= FV_SUPPORTED;
        ttc_pkg::REG_IRQ_STAT: rdata_o[ttc_pkg::IRQ_W-1:0] <= irq_stat;
        ttc_pkg::REG_IRQ_MASK: rdata_o[ttc_pkg::IRQ_W-1:0] <= irq_mask;
        ttc_pkg::REG_OP_POINT: rdata_o[ttc_pkg::XFER_TARGET_W-1:0] <= op_point_o;
        default: rdata_o <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_halt_sticky;
    @(posedge clk_i) disable iff (reset_i) catas_s |=> halt_o ##1 halt_o ##1 halt_o;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt not held");

  property p_catas_trips;
    @(posedge clk_i) disable iff (reset_i) catas_s |=> tripped;
  endproperty
  a_catas_trips: assert property (p_catas_trips) else $error("catastrophic no trip");

  property p_gate_cause;
    @(posedge clk_i) disable iff (reset_i)
      !clock_run_o |-> $past(duty_active) || $past(halt_o) || $past(catas_s);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("clock gated without cause");

  property p_enable_reset;
    @(posedge clk_i) $past(reset_i) |-> !misc_feature_enable_reg[ttc_pkg::MISC_DUTY_EN_BIT];
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable not cleared");

  property p_fv_target;
    @(posedge clk_i) disable iff (reset_i)
      fv_active |=> fv_active_o
      && op_point_o == $past(thermal_transition_control[ttc_pkg::XFER_TARGET_W-1:0]);
  endproperty
  a_fv_target: assert property (p_fv_target) else $error("target not applied");

  property p_perf_now;
    @(posedge clk_i) disable iff (reset_i)
      duty_active && wr_perf |=> op_point_o == $past(req_i.wdata[ttc_pkg::XFER_TARGET_W-1:0]);
  endproperty
  a_perf_now: assert property (p_perf_now) else $error("perf write not applied");

  property p_perf_defer;
    @(posedge clk_i) disable iff (reset_i)
      fv_active && wr_perf |=>
      op_point_o == $past(thermal_transition_control[ttc_pkg::XFER_TARGET_W-1:0]);
  endproperty
  a_perf_defer: assert property (p_perf_defer) else $error("perf write not deferred");

  property p_min_hold;
    @(posedge clk_i) disable iff (reset_i) $fell(tripped) |-> $past(hold_cnt) == '0;
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("released before hold");

  property p_status_read;
    @(posedge clk_i) disable iff (reset_i)
      req_i.rd && req_i.addr == ttc_pkg::REG_THERM_STAT
      |=> rdata_o[ttc_pkg::STAT_HOT_BIT] == $past(engaged);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bit wrong");

  property p_engaged_def;
    @(posedge clk_i) disable iff (reset_i)
      !tripped |=> !fv_active_o && (clock_run_o || $past(halt_o) || $past(catas_s));
  endproperty
  a_engaged_def: assert property (p_engaged_def) else $error("engaged wrong");

  property p_early_duty;
    @(posedge clk_i) disable iff (reset_i)
      EARLY_SCHEME && misc_feature_enable_reg[ttc_pkg::MISC_DUTY_EN_BIT]
      && !thermal_transition_control[ttc_pkg::XFER_SELECT_BIT]
      |-> duty_en == DUTY_SUPPORTED && !fv_en;
  endproperty
  a_early_duty: assert property (p_early_duty) else $error("early scheme wrong");

endmodule : ttc_top

// >>> sim/tb.sv
`timescale 1ns/1ns
// ****************************************************************
// Thermal throttle control bench
// ****************************************************************
module tb;
  localparam int MIN_CYC = 20;
  localparam int TIMEOUT_CYC = 20000;
  logic clk_i;
  logic reset_i;
  ttc_pkg::ttc_req_s req_i;
  logic [63:0] rdata_o;
  logic catas_trip_i;
  logic sensor_trip_i;
  logic temp_cool_i;
  logic halt_o;
  logic clock_run_o;
  logic fv_active_o;
  logic [15:0] op_point_o;
  logic irq_o;
  logic [63:0] rdata_e;
  logic halt_e;
  logic fv_active_e;
  logic [15:0] op_point_e;
  logic [63:0] rd_val;
  int fail_count;
  int n_checks;
  int cyc;

  // Short engage time keeps the run brief
  ttc_top #(.MIN_ENGAGE_CYCLES(MIN_CYC)) i_dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .catas_trip_i(catas_trip_i),
    .sensor_trip_i(sensor_trip_i),
    .temp_cool_i(temp_cool_i),
    .halt_o(halt_o),
    .clock_run_o(clock_run_o),
    .fv_active_o(fv_active_o),
    .op_point_o(op_point_o),
    .irq_o(irq_o)
  );

  // Second copy on the early enabling scheme, sharing every input
  ttc_top #(.MIN_ENGAGE_CYCLES(MIN_CYC), .EARLY_SCHEME(1'b1)) i_dut_early (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .req_i(req_i),
    .rdata_o(rdata_e),
    .catas_trip_i(catas_trip_i),
    .sensor_trip_i(sensor_trip_i),
    .temp_cool_i(temp_cool_i),
    .halt_o(halt_e),
    .clock_run_o(),
    .fv_active_o(fv_active_e),
    .op_point_o(op_point_e),
    .irq_o()
  );

  // Core clock, 4 ns
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check64(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check64

  task automatic check1(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : check1

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc

  // Strobe for one cycle, released at the sampling edge
  task automatic reg_wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk_i);
    req_i.wr <= 1'b1;
    req_i.addr <= a;
    req_i.wdata <= d;
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask : reg_wr

  // Read data appears at the sampling edge and holds until the next read strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_i);
    req_i.rd <= 1'b1;
    req_i.addr <= a;
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask : reg_rd

  task automatic rd_check(input logic [3:0] a, input logic [63:0] exp, input string msg);
    reg_rd(a);
    check64(rd_val, exp, msg);
  endtask : rd_check

  task automatic sensors(input logic trip, input logic cool);
    @(posedge clk_i);
    sensor_trip_i <= trip;
    temp_cool_i <= cool;
  endtask : sensors

  // Count gated cycles over a window
  task automatic count_low(input int n, input int exp, input string msg);
    int lows;
    lows = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (clock_run_o !== 1'b1) lows++;
    end
    check64(64'(lows), 64'(exp), msg);
  endtask : count_low

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_reset_regs();
    check1(clock_run_o, 1'b1, "clock after reset");
    check1(halt_o, 1'b0, "halt after reset");
    rd_check(ttc_pkg::REG_MISC_EN, 64'h0, "misc enable reset");
    rd_check(ttc_pkg::REG_XFER_CTL, 64'h0, "transition ctl reset");
    rd_check(ttc_pkg::REG_FEAT_EDX, 64'h0000_0000_2000_0000, "feature edx");
    rd_check(ttc_pkg::REG_FEAT_ECX, 64'h0000_0000_0000_0100, "feature ecx");
    rd_check(4'hf, 64'h0, "unmapped read");
    reg_wr(ttc_pkg::REG_MISC_EN, 64'hffff_ffff_ffff_ffff);
    reg_wr(ttc_pkg::REG_XFER_CTL, 64'hffff_ffff_ffff_ffff);
    reg_wr(ttc_pkg::REG_THERM_STAT, 64'hffff_ffff_ffff_ffff);
    rd_check(ttc_pkg::REG_MISC_EN, 64'h0000_0000_0000_2008, "misc enable bits");
    rd_check(ttc_pkg::REG_XFER_CTL, 64'h0000_0000_0001_ffff, "transition ctl bits");
    rd_check(ttc_pkg::REG_THERM_STAT, 64'h0, "status read only");
  endtask : sc_reset_regs

  // Trip with no method enabled must not throttle
  task automatic sc_no_method();
    reg_wr(ttc_pkg::REG_MISC_EN, 64'h0);
    sensors(1'b1, 1'b0);
    wait_cyc(10);
    rd_check(ttc_pkg::REG_THERM_STAT, 64'h0, "status without method");
    count_low(150, 0, "gating without method");
    check1(fv_active_o, 1'b0, "fv without method");
    sensors(1'b0, 1'b1);
    wait_cyc(MIN_CYC + 10);
    reg_wr(ttc_pkg::REG_IRQ_STAT, 64'h7);
  endtask : sc_no_method

  task automatic sc_duty();
    // Firmware enables the duty method once
    reg_wr(ttc_pkg::REG_MISC_EN, 64'h0000_0000_0000_0008);
    sensors(1'b1, 1'b0);
    wait_cyc(20);
    rd_check(ttc_pkg::REG_THERM_STAT, 64'h1, "status engaged");
    count_low(256, 128, "duty gating count");
    check1(fv_active_o, 1'b0, "no fv under duty");
    reg_wr(ttc_pkg::REG_PERF_TGT, 64'h0000_0000_0000_00a5);
    wait_cyc(2);
    check64(64'(op_point_o), 64'h00a5, "perf under duty");
    // Short trip, then cool: engaged must outlast the trip
    sensors(1'b0, 1'b0);
    wait_cyc(MIN_CYC + 20);
    rd_check(ttc_pkg::REG_THERM_STAT, 64'h1, "held until cool");
    sensors(1'b1, 1'b0);
    wait_cyc(3);
    sensors(1'b0, 1'b1);
    wait_cyc(8);
    rd_check(ttc_pkg::REG_THERM_STAT, 64'h1, "minimum engage");
    wait_cyc(MIN_CYC + 10);
    rd_check(ttc_pkg::REG_THERM_STAT, 64'h0, "released");
    count_low(150, 0, "no gating after release");
  endtask : sc_duty

  task automatic sc_irq();
    rd_check(ttc_pkg::REG_IRQ_STAT, 64'h3, "engage and release events");
    check1(irq_o, 1'b0, "irq masked");
    reg_wr(ttc_pkg::REG_IRQ_MASK, 64'h1);
    wait_cyc(3);
    check1(irq_o, 1'b1, "irq unmasked");
    reg_wr(ttc_pkg::REG_IRQ_STAT, 64'h1);
    wait_cyc(3);
    check1(irq_o, 1'b0, "irq cleared");
    rd_check(ttc_pkg::REG_IRQ_STAT, 64'h2, "one bit cleared");
    reg_wr(ttc_pkg::REG_IRQ_STAT, 64'h2);
    reg_wr(ttc_pkg::REG_IRQ_MASK, 64'h0);
  endtask : sc_irq

  task automatic sc_fv();
    int k;
    reg_wr(ttc_pkg::REG_XFER_CTL, 64'h0000_0000_0000_1234);
    reg_wr(ttc_pkg::REG_MISC_EN, 64'h0000_0000_0000_2000);
    sensors(1'b1, 1'b0);
    wait_cyc(8);
    check1(fv_active_o, 1'b1, "fv engaged");
    check64(64'(op_point_o), 64'h1234, "fv target applied");
    rd_check(ttc_pkg::REG_OP_POINT, 64'h1234, "op point register");
    count_low(150, 0, "no gating under fv");
    reg_wr(ttc_pkg::REG_PERF_TGT, 64'h0000_0000_0000_0055);
    wait_cyc(4);
    check64(64'(op_point_o), 64'h1234, "perf deferred");
    // Bench as software leaves enables and target field alone
    rd_check(ttc_pkg::REG_XFER_CTL, 64'h0000_0000_0000_1234, "target untouched");
    sensors(1'b0, 1'b1);
    k = 0;
    while (fv_active_o === 1'b1 && k < 200) begin
      wait_cyc(1);
      k++;
    end
    check1(fv_active_o, 1'b0, "fv released");
    wait_cyc(2);
    check64(64'(op_point_o), 64'h0055, "perf after release");
  endtask : sc_fv

  // Early scheme: select flag picks the method, bit 13 means nothing there
  task automatic sc_early();
    reg_wr(ttc_pkg::REG_XFER_CTL, 64'h0000_0000_0001_0777);
    reg_wr(ttc_pkg::REG_MISC_EN, 64'h0000_0000_0000_0008);
    sensors(1'b1, 1'b0);
    wait_cyc(8);
    check1(fv_active_e, 1'b1, "early fv with select");
    check64(64'(op_point_e), 64'h0777, "early fv target");
    check1(fv_active_o, 1'b0, "later scheme ignores select");
    reg_wr(ttc_pkg::REG_XFER_CTL, 64'h0000_0000_0000_0777);
    wait_cyc(3);
    check1(fv_active_e, 1'b0, "early select clear");
    reg_rd(ttc_pkg::REG_THERM_STAT);
    check1(rdata_e[ttc_pkg::STAT_HOT_BIT], 1'b1, "early duty engaged");
    sensors(1'b0, 1'b1);
    wait_cyc(MIN_CYC + 10);
    reg_wr(ttc_pkg::REG_IRQ_STAT, 64'h7);
  endtask : sc_early

  task automatic sc_catas();
    @(posedge clk_i);
    catas_trip_i <= 1'b1;
    wait_cyc(8);
    check1(halt_o, 1'b1, "halt on trip");
    check1(clock_run_o, 1'b0, "clock stopped");
    @(posedge clk_i);
    catas_trip_i <= 1'b0;
    sensors(1'b0, 1'b1);
    wait_cyc(MIN_CYC + 40);
    check1(halt_o, 1'b1, "halt is sticky");
    reg_rd(ttc_pkg::REG_IRQ_STAT);
    check1(rd_val[2], 1'b1, "catastrophic event");
    // Second reset in mid-run
    @(posedge clk_i);
    reset_i <= 1'b1;
    wait_cyc(2);
    @(posedge clk_i);
    reset_i <= 1'b0;
    wait_cyc(3);
    check1(halt_o, 1'b0, "halt cleared by reset");
    check1(halt_e, 1'b0, "early halt cleared by reset");
    check1(clock_run_o, 1'b1, "clock after reset");
    rd_check(ttc_pkg::REG_MISC_EN, 64'h0, "misc cleared by reset");
  endtask : sc_catas

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  initial begin
    fail_count = 0;
    n_checks = 0;
    reset_i = 1'b1;
    req_i = '0;
    catas_trip_i = 1'b0;
    sensor_trip_i = 1'b0;
    temp_cool_i = 1'b1;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    wait_cyc(1);
    sc_reset_regs();
    sc_no_method();
    sc_duty();
    sc_irq();
    sc_fv();
    sc_early();
    sc_catas();
    give_verdict();
  end

  // Ceiling well above the expected run length
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_i);
      cyc++;
      if (cyc == TIMEOUT_CYC) begin
        fail_count++;
        $display("MISMATCH %0t timeout", $time);
        give_verdict();
      end
    end
  end
endmodule : tb
